/* File: rtl/tol_output_stage.sv */
// output stage of the machine thermal overload function: levels, trip delay,
// blocking, condition and load codes, setting fault substitution, apb registers
// assumes image and setting inputs come from logic on pclk; block_in is a pin
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - first alarm asserts when enabled and capacity reaches its level, default 40 %
// - second alarm asserts when enabled and capacity reaches its level, default 40 %
// - restart lockout asserts when enabled and capacity reaches its level, default 80 %
// - trip judged by capacity against trip level, default 100 %, no enable
// - trip held off by settable delay in 5 ms steps, default zero
// - alarms and lockout act directly; only trip passes the blocking check
// - block input sampled at start of every program cycle
// - pick-up without blocking raises start and runs operate timing
// - pick-up with blocking raises blocked and goes no further
// - blocking during start clears start and releases as on pick-up reset
// - blocking issues display event and blocking event with current and fault type
// - software switch drives blocking only while stage forcing is enabled
// - condition code 0..5; normal code means no outputs driven except start
// - load status code 0 stopped to 4 running normal
// - load classed by current: light, normal, overloading, high overload
// - invalid service factor flags a fault and uses 1.0
// - invalid ambient settings flag a fault and use 1.0
// - invalid nominal current flags a fault and uses 1.0
// - inconsistent ambient k flagged only while the fault exists
module tol_output_stage import tol_pkg::*; #(
  parameter int unsigned CYCLE_CLKS = PROG_CYCLE_CLKS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // thermal image and settings
  input wire tol_image_s image,
  input wire tol_setting_s setting,
  // blocking matrix pin
  input wire logic block_in,
  // outputs to i/o and event logging
  output tol_out_s outs,
  output tol_cond_e condition,
  output tol_load_e load_status,
  output logic [3:0] setting_fault_flag,
  output tol_used_s used,
  output logic display_event,
  output logic block_event,
  output tol_event_s block_event_data
);

  // a cycle of one clock would never leave the tick state
  if (CYCLE_CLKS < 2) begin : g_cycle_short
    $error("tol_output_stage: CYCLE_CLKS below 2");
  end
  if (CYCLE_CLKS > 32'h00ffffff) begin : g_cycle_long
    $error("tol_output_stage: CYCLE_CLKS exceeds the 24-bit counter");
  end

  // ==========================================================
  // program cycle tick
  // count starts at zero, so the first tick falls on the first edge after reset
  logic [23:0] cyc_cnt;
  logic tick;
  assign tick = (cyc_cnt == 24'h000000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_cnt <= 24'h000000;
    end else if (tick) begin
      cyc_cnt <= 24'(CYCLE_CLKS - 1);
    end else begin
      cyc_cnt <= cyc_cnt - 24'h000001;
    end
  end

  // ==========================================================
  // block pin synchroniser
  // only the second stage feeds logic; the first may go metastable
  logic blk_meta;
  logic blk_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_meta <= 1'b0;
      blk_sync <= 1'b0;
    end else begin
      blk_meta <= block_in;
      blk_sync <= blk_meta;
    end
  end

  // ==========================================================
  // registers
  logic [4:0] ctrl;
  logic [LEVEL_W-1:0] alarm1_level;
  logic [LEVEL_W-1:0] alarm2_level;
  logic [LEVEL_W-1:0] lockout_level;
  logic [LEVEL_W-1:0] trip_level;
  logic [DELAY_W-1:0] trip_delay;
  logic [1:0] event_flags;

  wire access = psel & penable;
  wire wr = access & pwrite & pstrb[0];
  wire hit_ctrl = (paddr == CTRL_OFS);
  wire hit_a1 = (paddr == ALARM1_LEVEL_OFS);
  wire hit_a2 = (paddr == ALARM2_LEVEL_OFS);
  wire hit_lo = (paddr == LOCKOUT_LEVEL_OFS);
  wire hit_tr = (paddr == TRIP_LEVEL_OFS);
  wire hit_dl = (paddr == TRIP_DELAY_OFS);
  wire hit_st = (paddr == STATUS_OFS);
  wire hit_ev = (paddr == EVENT_OFS);
  wire mapped = hit_ctrl | hit_a1 | hit_a2 | hit_lo | hit_tr | hit_dl | hit_st | hit_ev;

  // levels above 150.0 % in the low 11 bits of pwdata saturate; higher pwdata bits are dropped, so those wrap
  wire [LEVEL_W-1:0] wr_level = (pwdata[LEVEL_W-1:0] > LEVEL_MAX) ? LEVEL_MAX : pwdata[LEVEL_W-1:0];
  wire [DELAY_W-1:0] wr_delay = (pwdata[DELAY_W-1:0] > TRIP_DELAY_MAX) ? TRIP_DELAY_MAX : pwdata[DELAY_W-1:0];
  // delay field spans three byte lanes; all three must be enabled
  wire wr_delay_ok = wr & hit_dl & pstrb[1] & pstrb[2];
  wire wr_level_ok = wr & pstrb[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      alarm1_level <= ALARM1_LEVEL_RESET;
      alarm2_level <= ALARM2_LEVEL_RESET;
      lockout_level <= LOCKOUT_LEVEL_RESET;
      trip_level <= TRIP_LEVEL_RESET;
      trip_delay <= TRIP_DELAY_RESET;
    end else begin
      if (wr & hit_ctrl) begin
        ctrl <= pwdata[4:0];
      end
      if (wr_level_ok & hit_a1) begin
        alarm1_level <= wr_level;
      end
      if (wr_level_ok & hit_a2) begin
        alarm2_level <= wr_level;
      end
      if (wr_level_ok & hit_lo) begin
        lockout_level <= wr_level;
      end
      if (wr_level_ok & hit_tr) begin
        trip_level <= wr_level;
      end
      if (wr_delay_ok) begin
        trip_delay <= wr_delay;
      end
    end
  end

  // ==========================================================
  // blocking source and sampling
  logic blk_cycle;
  wire blk_src = blk_sync | (ctrl[CTRL_FORCING_BIT] & ctrl[CTRL_SW_BLOCK_BIT]);

  // sampled once per cycle, so a late block waits a full 5 ms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_cycle <= 1'b0;
    end else if (tick) begin
      blk_cycle <= blk_src;
    end
  end

  // ==========================================================
  // comparators
  wire a1_pick = ctrl[CTRL_ALARM1_EN_BIT] & (image.capacity >= alarm1_level);
  wire a2_pick = ctrl[CTRL_ALARM2_EN_BIT] & (image.capacity >= alarm2_level);
  wire lo_pick = ctrl[CTRL_LOCKOUT_EN_BIT] & (image.capacity >= lockout_level);
  wire tr_pick = (image.capacity >= trip_level);

  // ==========================================================
  // trip sequence
  tol_state_e state;
  tol_state_e next_state;
  logic [DELAY_W-1:0] dly_cnt;
  logic [DELAY_W-1:0] next_dly_cnt;
  wire dly_done = (dly_cnt >= trip_delay);

  always_comb begin
    next_state = state;
    next_dly_cnt = dly_cnt;
    case (state)
      ST_IDLE: begin
        next_dly_cnt = {DELAY_W{1'b0}};
        if (tr_pick && blk_cycle) begin
          next_state = ST_BLOCKED;
        end else if (tr_pick) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        // blocking is checked before the delay, so it wins over an expiring count
        if (!tr_pick) begin
          next_state = ST_IDLE;
        end else if (blk_cycle) begin
          next_state = ST_BLOCKED;
        end else if (dly_done) begin
          next_state = ST_TRIP;
        end else begin
          next_dly_cnt = dly_cnt + {{(DELAY_W-1){1'b0}}, 1'b1};
        end
      end
      ST_TRIP: begin
        if (!tr_pick) begin
          next_state = ST_IDLE;
        end
      end
      ST_BLOCKED: begin
        // release path as on pick-up reset; a fresh start needs the block gone
        if (!tr_pick || !blk_cycle) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // zero delay trips on the cycle after start, not in the same one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      dly_cnt <= {DELAY_W{1'b0}};
    end else if (tick) begin
      state <= next_state;
      dly_cnt <= next_dly_cnt;
    end
  end

  // ==========================================================
  // outputs, condition and load codes
  logic prev_running;
  wire cur_light = (image.current < CUR_LIGHT);
  wire cur_high = (image.current > CUR_HIGH);
  wire cur_over = (image.current > image.pickup_current);
  wire enter_block = tick & (state != ST_BLOCKED) & (next_state == ST_BLOCKED);

  tol_cond_e next_cond;
  tol_load_e next_load;

  // condition follows the state being entered, so it moves together with outs
  always_comb begin
    if (next_state == ST_BLOCKED) begin
      next_cond = COND_BLOCKED;
    end else if (next_state == ST_TRIP) begin
      next_cond = COND_TRIP;
    end else if (lo_pick) begin
      next_cond = COND_LOCKOUT;
    end else if (a2_pick) begin
      next_cond = COND_ALARM2;
    end else if (a1_pick) begin
      next_cond = COND_ALARM1;
    end else begin
      next_cond = COND_NORMAL;
    end
  end

  // just stopped stands for one program cycle only
  always_comb begin
    if (cur_light && prev_running) begin
      next_load = LOAD_JUST_STOPPED;
    end else if (cur_light) begin
      next_load = LOAD_STOPPED;
    end else if (cur_high) begin
      next_load = LOAD_STALLED;
    end else if (cur_over) begin
      next_load = LOAD_OVERLOADING;
    end else begin
      next_load = LOAD_RUNNING;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outs <= '0;
      condition <= COND_NORMAL;
      load_status <= LOAD_STOPPED;
      prev_running <= 1'b0;
    end else if (tick) begin
      outs.alarm1 <= a1_pick;
      outs.alarm2 <= a2_pick;
      outs.lockout <= lo_pick;
      outs.trip <= (next_state == ST_TRIP);
      outs.start <= (next_state == ST_START);
      outs.blocked <= (next_state == ST_BLOCKED);
      condition <= next_cond;
      load_status <= next_load;
      prev_running <= ~cur_light;
    end
  end

  // ==========================================================
  // blocking events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_event <= 1'b0;
      block_event <= 1'b0;
      block_event_data <= '0;
    end else begin
      display_event <= enter_block;
      block_event <= enter_block;
      if (enter_block) begin
        block_event_data.fault_type <= COND_TRIP;
        block_event_data.capacity <= image.capacity;
        block_event_data.current <= image.current;
      end
    end
  end

  // sticky copy for software; a new block beats a same-cycle clear
  wire leave_block = tick & (state == ST_BLOCKED) & (next_state != ST_BLOCKED);
  wire clr_entered = wr & hit_ev & pwdata[0];
  wire clr_released = wr & hit_ev & pwdata[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flags <= 2'h0;
    end else begin
      event_flags[0] <= enter_block | (event_flags[0] & ~clr_entered);
      event_flags[1] <= leave_block | (event_flags[1] & ~clr_released);
    end
  end

  // ==========================================================
  // setting fault substitution, live while the fault stands
  assign setting_fault_flag[0] = ~setting.service_factor_ok;
  assign setting_fault_flag[1] = ~setting.ambient_ok;
  assign setting_fault_flag[2] = ~setting.nominal_ok;
  assign setting_fault_flag[3] = ~setting.ambient_k_consistent;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      used <= {FACTOR_ONE, FACTOR_ONE, FACTOR_ONE};
    end else begin
      used.service_factor <= setting.service_factor_ok ? setting.service_factor : FACTOR_ONE;
      used.ambient_k <= setting.ambient_ok ? setting.ambient_k : FACTOR_ONE;
      used.nominal_current <= setting.nominal_ok ? setting.nominal_current : FACTOR_ONE;
    end
  end

  // ==========================================================
  // apb read side, zero wait states
  wire [31:0] status_word = (32'(condition) << STATUS_COND_POS)
                          | (32'(load_status) << STATUS_LOAD_POS)
                          | (32'(setting_fault_flag) << STATUS_FAULT_POS)
                          | (32'(outs) << STATUS_OUT_POS);
  wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl)
                     : hit_a1 ? 32'(alarm1_level)
                     : hit_a2 ? 32'(alarm2_level)
                     : hit_lo ? 32'(lockout_level)
                     : hit_tr ? 32'(trip_level)
                     : hit_dl ? 32'(trip_delay)
                     : hit_st ? status_word
                     : hit_ev ? 32'(event_flags)
                     : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  // prdata reads zero outside a read access to keep the bus quiet
  assign prdata = (access & ~pwrite) ? rd_mux : 32'h00000000;

endmodule : tol_output_stage

/* File: rtl/tol_pkg.sv */
// constants, field layouts and carrier types of the thermal overload output stage
// assumes a 100 MHz pclk and an apb master with 32-bit data
package tol_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ALARM1_LEVEL_OFS = 8'h04;
  localparam logic [7:0] ALARM2_LEVEL_OFS = 8'h08;
  localparam logic [7:0] LOCKOUT_LEVEL_OFS = 8'h0c;
  localparam logic [7:0] TRIP_LEVEL_OFS = 8'h10;
  localparam logic [7:0] TRIP_DELAY_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] EVENT_OFS = 8'h1c;

  // ==========================================================
  // control bits
  localparam int CTRL_ALARM1_EN_BIT = 0;
  localparam int CTRL_ALARM2_EN_BIT = 1;
  localparam int CTRL_LOCKOUT_EN_BIT = 2;
  localparam int CTRL_FORCING_BIT = 3;
  localparam int CTRL_SW_BLOCK_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // ==========================================================
  // status fields
  localparam int STATUS_COND_POS = 0;
  localparam int STATUS_LOAD_POS = 4;
  localparam int STATUS_FAULT_POS = 8;
  localparam int STATUS_OUT_POS = 16;

  // ==========================================================
  // levels in 0.1 % steps, delay in 5 ms steps
  localparam int LEVEL_W = 11;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 11'h5dc;
  localparam logic [LEVEL_W-1:0] ALARM1_LEVEL_RESET = 11'h190;
  localparam logic [LEVEL_W-1:0] ALARM2_LEVEL_RESET = 11'h190;
  localparam logic [LEVEL_W-1:0] LOCKOUT_LEVEL_RESET = 11'h320;
  localparam logic [LEVEL_W-1:0] TRIP_LEVEL_RESET = 11'h3e8;
  localparam int DELAY_W = 20;
  localparam logic [DELAY_W-1:0] TRIP_DELAY_MAX = 20'hafc80;
  localparam logic [DELAY_W-1:0] TRIP_DELAY_RESET = 20'h00000;

  // ==========================================================
  // current and factor scaling, 0.01 x nominal per lsb
  localparam int CUR_W = 16;
  localparam logic [CUR_W-1:0] CUR_LIGHT = 16'h0001;
  localparam logic [CUR_W-1:0] CUR_HIGH = 16'h00c8;
  localparam logic [CUR_W-1:0] FACTOR_ONE = 16'h0064;

  // ==========================================================
  // program cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_CYCLE_NS = 5000000;
  localparam int PROG_CYCLE_CLKS = PROG_CYCLE_NS / CLK_PERIOD_NS;

  // ==========================================================
  // codes
  typedef enum logic [2:0] {
    COND_NORMAL = 3'h0,
    COND_ALARM1 = 3'h1,
    COND_ALARM2 = 3'h2,
    COND_LOCKOUT = 3'h3,
    COND_TRIP = 3'h4,
    COND_BLOCKED = 3'h5
  } tol_cond_e;

  typedef enum logic [2:0] {
    LOAD_STOPPED = 3'h0,
    LOAD_STALLED = 3'h1,
    LOAD_JUST_STOPPED = 3'h2,
    LOAD_OVERLOADING = 3'h3,
    LOAD_RUNNING = 3'h4
  } tol_load_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_TRIP = 2'h2,
    ST_BLOCKED = 2'h3
  } tol_state_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [LEVEL_W-1:0] capacity;
    logic [CUR_W-1:0] current;
    logic [CUR_W-1:0] pickup_current;
  } tol_image_s;

  typedef struct packed {
    logic [CUR_W-1:0] service_factor;
    logic service_factor_ok;
    logic [CUR_W-1:0] ambient_k;
    logic ambient_ok;
    logic [CUR_W-1:0] nominal_current;
    logic nominal_ok;
    logic ambient_k_consistent;
  } tol_setting_s;

  typedef struct packed {
    logic [CUR_W-1:0] service_factor;
    logic [CUR_W-1:0] ambient_k;
    logic [CUR_W-1:0] nominal_current;
  } tol_used_s;

  typedef struct packed {
    logic alarm1;
    logic alarm2;
    logic lockout;
    logic trip;
    logic start;
    logic blocked;
  } tol_out_s;

  typedef struct packed {
    logic [2:0] fault_type;
    logic [LEVEL_W-1:0] capacity;
    logic [CUR_W-1:0] current;
  } tol_event_s;

endpackage : tol_pkg

/* File: verification/tol_output_stage_monitor.sv */
// concurrent checks on the ports of the thermal overload output stage
// assumes one pclk domain and the apb write timing of the stage
`timescale 1ns/1ps
module tol_output_stage_chk import tol_pkg::*; (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // stage signals
  input wire tol_setting_s setting,
  input wire tol_out_s outs,
  input wire tol_cond_e condition,
  input wire logic [3:0] setting_fault_flag,
  input wire tol_used_s used,
  input wire logic display_event,
  input wire logic block_event,
  input wire tol_event_s block_event_data
);
  // ==========
  // shadow of the enables, not visible at the outputs
  logic [2:0] en_q;
  tol_used_s exp_used;
  wire en_wr = psel && penable && pwrite && paddr == CTRL_OFS && pstrb[0];
  assign exp_used = {setting.service_factor_ok ? setting.service_factor : FACTOR_ONE,
    setting.ambient_ok ? setting.ambient_k : FACTOR_ONE,
    setting.nominal_ok ? setting.nominal_current : FACTOR_ONE};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_q <= 3'h0;
    else if (en_wr) en_q <= pwdata[2:0];
  end
  // ==========
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_entered;
    outs.blocked && display_event && block_event_data.fault_type == 3'h4;
  endsequence
  sequence s_pulse;
    block_event ##1 !block_event;
  endsequence
  // enables as they stood during the tick cycle, one clock before the output shows
  AST_A1_EN: assert property ($rose(outs.alarm1) |-> $past(en_q[0]))
    else $error("alarm1 rose while disabled");
  AST_A2_EN: assert property ($rose(outs.alarm2) |-> $past(en_q[1]))
    else $error("alarm2 rose while disabled");
  AST_LO_EN: assert property ($rose(outs.lockout) |-> $past(en_q[2]))
    else $error("lockout rose while disabled");
  AST_TRIP_COND: assert property (outs.trip |-> condition == COND_TRIP && !outs.start)
    else $error("trip without trip condition");
  AST_BLK_COND: assert property (outs.blocked |-> condition == COND_BLOCKED && !outs.trip)
    else $error("blocked without blocked condition");
  AST_START_BLK: assert property (outs.start |-> !outs.blocked)
    else $error("start and blocked together");
  AST_EVENT: assert property (block_event |-> s_entered ##0 s_pulse)
    else $error("block event malformed");
  AST_NORMAL: assert property (condition == COND_NORMAL |->
    !(outs.alarm1 || outs.alarm2 || outs.lockout || outs.trip || outs.blocked))
    else $error("outputs driven in normal condition");
  AST_FLAGS: assert property (setting_fault_flag == {!setting.ambient_k_consistent,
    !setting.nominal_ok, !setting.ambient_ok, !setting.service_factor_ok})
    else $error("setting fault flags wrong");
  AST_USED: assert property (1'b1 |=> used == $past(exp_used))
    else $error("used factors wrong");
endmodule : tol_output_stage_chk

bind tol_output_stage tol_output_stage_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .setting(setting),
  .outs(outs), .condition(condition), .setting_fault_flag(setting_fault_flag), .used(used),
  .display_event(display_event), .block_event(block_event), .block_event_data(block_event_data));

/* File: verification/tol_block_matrix.sv */
// model of the blocking matrix that drives the block pin
// assumes the bench requests blocking a program cycle ahead of any delay expiry
`timescale 1ns/1ps
module tol_block_matrix (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the bench
  input wire logic block_req,
  // block pin
  output logic block_in
);
  // ==========
  // pin moves only just after an edge; follows block_req one clock later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) block_in <= 1'b0;
    else block_in <= block_req;
  end
endmodule : tol_block_matrix

/* File: verification/test_thermal_overload_output_logic.sv */
// self-checking bench of the thermal overload output stage
// assumes the block matrix model and the bound checker; program cycle shortened to 10 clocks
`timescale 1ns/1ps
module test_thermal_overload_output_logic import tol_pkg::*;;
  // ==========
  // signals
  localparam int CYC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic block_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, block_in, display_event, block_event;
  logic [3:0] setting_fault_flag;
  tol_image_s image = '0;
  tol_setting_s setting = {16'h0050, 1'b1, 16'h0078, 1'b1, 16'h00c8, 1'b1, 1'b1};
  tol_out_s outs;
  tol_cond_e condition;
  tol_load_e load_status;
  tol_used_s used;
  tol_event_s block_event_data;
  int num_errors = 0;
  int checks_done = 0;
  int ecnt = 0;
  logic [7:0] ofs [6] = '{CTRL_OFS, ALARM1_LEVEL_OFS, ALARM2_LEVEL_OFS, LOCKOUT_LEVEL_OFS, TRIP_LEVEL_OFS,
    TRIP_DELAY_OFS};
  logic [31:0] dfl [6] = '{32'h0, 32'h190, 32'h190, 32'h320, 32'h3e8, 32'h0};
  logic [15:0] cur [5] = '{16'h0032, 16'h0096, 16'h012c, 16'h0000, 16'h0000};
  tol_load_e lexp [5] = '{LOAD_RUNNING, LOAD_OVERLOADING, LOAD_STALLED, LOAD_JUST_STOPPED, LOAD_STOPPED};

  always #5 pclk = ~pclk;
  // edges since release; a tick is where the old count is a multiple of CYC
  always @(posedge pclk) ecnt <= presetn ? ecnt + 1 : 0;

  tol_block_matrix u_matrix (.pclk(pclk), .presetn(presetn), .block_req(block_req), .block_in(block_in));
  tol_output_stage #(.CYCLE_CLKS(CYC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .image(image), .setting(setting), .block_in(block_in), .outs(outs),
    .condition(condition), .load_status(load_status), .setting_fault_flag(setting_fault_flag), .used(used),
    .display_event(display_event), .block_event(block_event), .block_event_data(block_event_data));

  // ==========
  // tasks
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // stay two edges after a tick so every wait of whole cycles sees exactly one update
  task automatic align();
    while (ecnt % CYC != 2) @(posedge pclk);
  endtask : align

  task automatic step(input int n);
    repeat (n * CYC) @(posedge pclk);
  endtask : step

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      num_errors++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
    align();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk("prdata", {16'h0, exp}, {16'h0, r});
    chk("pslverr", {47'h0, exp_err}, {47'h0, e});
    align();
  endtask : rd

  task automatic co(input logic [5:0] eo, input tol_cond_e ec);
    chk("outs", {42'h0, eo}, {42'h0, outs});
    chk("condition", {45'h0, ec}, {45'h0, condition});
  endtask : co

  // ==========
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end

  // ==========
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    align();
    foreach (ofs[i]) rd(ofs[i], dfl[i], 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(ALARM2_LEVEL_OFS, 32'h7ff);
    rd(ALARM2_LEVEL_OFS, 32'h5dc, 1'b0);
    wr(ALARM2_LEVEL_OFS, 32'h190);
    wr(ALARM1_LEVEL_OFS, 32'h12c);
    // alarms and lockout, enables off then on
    image.capacity <= 11'h12c;
    step(1);
    co(6'b000000, COND_NORMAL);
    wr(CTRL_OFS, 32'h7);
    step(1);
    co(6'b100000, COND_ALARM1);
    image.capacity <= 11'h190;
    step(1);
    co(6'b110000, COND_ALARM2);
    image.capacity <= 11'h320;
    step(1);
    co(6'b111000, COND_LOCKOUT);
    image.capacity <= 11'h31f;
    step(1);
    co(6'b110000, COND_ALARM2);
    image.capacity <= 11'h0;
    wr(CTRL_OFS, 32'h0);
    step(1);
    // trip, no delay then two program cycles
    image.capacity <= 11'h3e8;
    step(1);
    co(6'b000010, COND_NORMAL);
    step(1);
    co(6'b000100, COND_TRIP);
    image.capacity <= 11'h3e7;
    step(1);
    co(6'b000000, COND_NORMAL);
    wr(TRIP_DELAY_OFS, 32'h2);
    image.capacity <= 11'h3e8;
    step(1);
    co(6'b000010, COND_NORMAL);
    step(2);
    co(6'b000010, COND_NORMAL);
    step(1);
    co(6'b000100, COND_TRIP);
    image.capacity <= 11'h0;
    block_req <= 1'b1;
    step(1);
    // pick-up while blocked, then blocking after start
    image.capacity <= 11'h3e8;
    step(1);
    co(6'b000001, COND_BLOCKED);
    chk("block_data", {18'h0, 3'h4, 11'h3e8, 16'h0000}, {18'h0, block_event_data});
    image.capacity <= 11'h0;
    block_req <= 1'b0;
    step(1);
    wr(TRIP_DELAY_OFS, 32'h64);
    image.capacity <= 11'h3e8;
    step(1);
    co(6'b000010, COND_NORMAL);
    block_req <= 1'b1;
    // the pin is sampled at one tick and acted on at the next
    step(1);
    co(6'b000010, COND_NORMAL);
    step(1);
    co(6'b000001, COND_BLOCKED);
    image.capacity <= 11'h0;
    block_req <= 1'b0;
    step(2);
    rd(EVENT_OFS, 32'h3, 1'b0);
    wr(EVENT_OFS, 32'h3);
    rd(EVENT_OFS, 32'h0, 1'b0);
    // software block ignored without forcing, honoured with it
    wr(CTRL_OFS, 32'h10);
    image.capacity <= 11'h3e8;
    step(1);
    co(6'b000010, COND_NORMAL);
    image.capacity <= 11'h0;
    wr(CTRL_OFS, 32'h18);
    image.capacity <= 11'h3e8;
    step(1);
    co(6'b000001, COND_BLOCKED);
    image.capacity <= 11'h0;
    wr(CTRL_OFS, 32'h0);
    // load status
    image.pickup_current <= 16'h0078;
    foreach (cur[i]) begin
      image.current <= cur[i];
      step(1);
      chk("load", {45'h0, lexp[i]}, {45'h0, load_status});
    end
    // setting faults substitute 1.0
    setting.service_factor_ok <= 1'b0;
    setting.ambient_ok <= 1'b0;
    setting.nominal_ok <= 1'b0;
    setting.ambient_k_consistent <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("flags", 48'hf, {44'h0, setting_fault_flag});
    chk("used", {FACTOR_ONE, FACTOR_ONE, FACTOR_ONE}, used);
    setting <= {16'h0050, 1'b1, 16'h0078, 1'b1, 16'h00c8, 1'b1, 1'b1};
    repeat (2) @(posedge pclk);
    chk("flags", 48'h0, {44'h0, setting_fault_flag});
    chk("used", {16'h0050, 16'h0078, 16'h00c8}, used);
    end_sim();
  end
endmodule : test_thermal_overload_output_logic
